// [dv/dlr_headend_model.sv]
`timescale 1ns/10ps
`default_nettype none
// far-end model: answers each ranging request after a chosen delay
module dlr_headend_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire dlr_pkg::dlr_rng_req_t rng_req,
   input wire logic status_report,
   input wire logic [3:0] answer_delay,
   input wire logic abort_mode,
   output logic ranging_response_success,
   output logic ranging_response_timeout,
   output logic bonding_change_request
);
   logic [4:0] wait_reg; // cycles left before the answer, zero when idle
   // every request from a modem in normal operation is processed
   // abort mode stands for a stale ranging identifier: the attempt fails
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg <= 5'h00;
         ranging_response_success <= 1'b0;
         ranging_response_timeout <= 1'b0;
         bonding_change_request <= 1'b0;
      end else begin
         ranging_response_success <= 1'b0;
         ranging_response_timeout <= 1'b0;
         // learning of the outage, the far end reprograms the channel set
         bonding_change_request <= status_report;
         if (rng_req.valid) begin
            wait_reg <= {1'b0, answer_delay} + 5'h01;
         end else if (wait_reg == 5'h01) begin
            wait_reg <= 5'h00;
            ranging_response_success <= !abort_mode;
            ranging_response_timeout <= abort_mode;
         end else if (wait_reg != 5'h00) begin
            wait_reg <= wait_reg - 5'h01;
         end
      end
   end
endmodule : dlr_headend_model
`default_nettype wire

// [dv/dlr_lock_supervisor_test.sv]
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the lock supervisor
module dlr_lock_supervisor_test;
   logic sys_clk = 1'b0, rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   dlr_pkg::dlr_qam_t qam = 4'h0;
   dlr_pkg::dlr_mc_t mc = 10'h000;
   logic backup_avail = 1'b0, map_chan = 1'b0, params_same = 1'b0, upstream_ok = 1'b0;
   logic rng_ok, rng_to, skew_done = 1'b0, abort_mode = 1'b0;
   logic [3:0] answer_delay = 4'h1;
   logic ds_valid, lost_lock, switch_backup, seek_map, partial_mode, status_report;
   logic tx_hold, us_suspend, mac_reinit;
   dlr_pkg::dlr_rng_req_t rng_req;
   int mismatches = 0, total_checks = 0;
   int n_lost, n_stat, n_sw, n_reinit;
   int sticky_model = 0; // expected sticky flags, kept by the bench
   // short counts so outages resolve in a few hundred cycles
   localparam int SHORT = 20;
   localparam int RECOVER = 200;
   always #10 sys_clk = ~sys_clk;
   dlr_lock_supervisor #(.SHORT_CYC(SHORT), .RECOVER_CYC(RECOVER)) u_dlr_lock_supervisor (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .qam_pin(qam), .mc_pin(mc),
      .backup_avail_pin(backup_avail), .map_channel_pin(map_chan), .params_same(params_same),
      .upstream_ok(upstream_ok), .ranging_response_success(rng_ok), .ranging_response_timeout(rng_to),
      .skew_done(skew_done), .ds_valid(ds_valid), .lost_lock(lost_lock),
      .switch_backup(switch_backup), .seek_map_channel(seek_map), .partial_mode(partial_mode),
      .status_report(status_report), .tx_hold(tx_hold), .us_suspend(us_suspend),
      .mac_reinit(mac_reinit), .rng_req(rng_req));
   dlr_headend_model u_dlr_headend_model (
      .sys_clk(sys_clk), .rst_n(rst_n), .rng_req(rng_req), .status_report(status_report),
      .answer_delay(answer_delay), .abort_mode(abort_mode), .ranging_response_success(rng_ok),
      .ranging_response_timeout(rng_to), .bonding_change_request());
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic check1(input string what, input logic seen, input logic exp);
      check(what, {31'h0, seen}, {31'h0, exp});
   endtask : check1
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // read data are looked at only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check(what, reg_rdata, exp);
   endtask : rd
   // counts one-cycle pulses over a span, sampled once they settle
   task automatic watch(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         n_lost += int'(lost_lock === 1'b1);
         n_stat += int'(status_report === 1'b1);
         n_sw += int'(switch_backup === 1'b1);
         n_reinit += int'(mac_reinit === 1'b1);
      end
   endtask : watch
   task automatic clr();
      n_lost = 0;
      n_stat = 0;
      n_sw = 0;
      n_reinit = 0;
   endtask : clr
   // every ranging request is checked as it leaves the block
   always @(posedge sys_clk) begin
      if (rng_req.valid === 1'b1) begin
         check1("spreader", rng_req.spreader_on, 1'b0);
         check1("offset", rng_req.use_offset, rng_req.kind == dlr_pkg::DLR_RNG_STATION);
      end
   end
   // cuts a hang short well past the expected run length
   initial begin
      repeat (30000) @(posedge sys_clk);
      mismatches++;
      close_out();
   end
   initial begin
      logic [31:0] r;
      int k;
      void'($urandom(32'h9c104129));
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(dlr_pkg::DLR_ADDR_CTRL, dlr_pkg::DLR_CTRL_RESET, "ctrl");
      rd(dlr_pkg::DLR_ADDR_LOSTSYNC, dlr_pkg::DLR_LOSTSYNC_RESET, "lostsync");
      rd(dlr_pkg::DLR_ADDR_STMAINT, dlr_pkg::DLR_STMAINT_RESET, "stmaint");
      rd(dlr_pkg::DLR_ADDR_RNGRSP, dlr_pkg::DLR_RNGRSP_RESET, "rngrsp");
      rd(4'hF, 32'h0, "unmapped");
      r = $urandom;
      wr(dlr_pkg::DLR_ADDR_RNGRSP, r);
      rd(dlr_pkg::DLR_ADDR_RNGRSP, r, "rngrsp rw");
      wr(dlr_pkg::DLR_ADDR_RNGRSP, 32'h00000028);
      wr(dlr_pkg::DLR_ADDR_LOSTSYNC, 32'h0000003C);
      // qam primary: valid needs all four conditions
      @(posedge sys_clk);
      qam <= 4'hF;
      params_same <= 1'b1;
      upstream_ok <= 1'b1;
      watch(6);
      check1("qam valid", ds_valid, 1'b1);
      clr();
      qam <= 4'hE;
      watch(6);
      check1("sync msg", ds_valid, 1'b0);
      check("sync no loss", n_lost, 0);
      qam <= 4'hF;
      // each sync loss for a short random outage, last one with no upstream
      for (int i = 0; i < 3; i++) begin
         watch(6);
         clr();
         upstream_ok <= (i != 2);
         answer_delay <= 4'($urandom_range(1, 8));
         qam <= 4'hF & ~(4'h8 >> i);
         k = $urandom_range(3, 10);
         watch(k);
         qam <= 4'hF;
         watch(RECOVER + 40);
         check("qam loss", n_lost, 1);
         check("report", n_stat, int'(i != 2));
         check1("resumed", tx_hold, 1'b0);
         sticky_model |= 1;
         rd(dlr_pkg::DLR_ADDR_STICKY, sticky_model, "sticky qam");
         wr(dlr_pkg::DLR_ADDR_STICKY, 32'h1);
         sticky_model &= ~1;
         rd(dlr_pkg::DLR_ADDR_STICKY, sticky_model, "sticky clr");
         @(posedge sys_clk);
      end
      // multicarrier primary with backup assigned
      upstream_ok <= 1'b1;
      wr(dlr_pkg::DLR_ADDR_CTRL, 32'h6);
      mc <= 10'h3C1;
      watch(6);
      check1("mc valid", ds_valid, 1'b1);
      for (int j = 0; j < 3; j++) begin
         clr();
         mc <= 10'h3C1 | (10'h008 >> j);
         watch(8);
         check1("partial", partial_mode, 1'b1);
         check("soft loss", n_lost, 1);
         check("soft kept", n_sw, 0);
         mc <= 10'h3C1;
         watch(8);
         check1("partial off", partial_mode, 1'b0);
         sticky_model |= (1 << (3 + j)) | 32'h40;
      end
      rd(dlr_pkg::DLR_ADDR_STICKY, sticky_model, "sticky soft");
      wr(dlr_pkg::DLR_ADDR_STICKY, 32'h7F);
      sticky_model = 0;
      // pilot loss with a backup ready: switch, skew known from ctrl, hold until ranging answered
      clr();
      backup_avail <= 1'b1;
      map_chan <= 1'b1;
      mc <= 10'h3E1;
      watch(8);
      check("pilot loss", n_lost, 1);
      check("switch", n_sw, 1);
      check1("seek map", seek_map, 1'b1);
      check1("skew hold", tx_hold, 1'b1);
      skew_done <= 1'b1;
      @(posedge sys_clk);
      skew_done <= 1'b0;
      mc <= 10'h3C1;
      watch(RECOVER + 40);
      sticky_model |= 2;
      rd(dlr_pkg::DLR_ADDR_STICKY, sticky_model, "sticky pilot");
      // preamble loss, no backup, every ranging attempt fails
      clr();
      wr(dlr_pkg::DLR_ADDR_CTRL, 32'h0);
      abort_mode <= 1'b1;
      mc <= 10'h3D0;
      watch(200);
      check1("suspend", us_suspend, 1'b1);
      watch(3800);
      check("pre loss", n_lost, 1);
      check("no switch", n_sw, 0);
      check("reinit", n_reinit, 1);
      sticky_model |= 4;
      rd(dlr_pkg::DLR_ADDR_STICKY, sticky_model, "sticky pre");
      close_out();
   end
endmodule : dlr_lock_supervisor_test
`default_nettype wire

// [verilog/dlr_lock_supervisor.sv]
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// downstream lock supervisor and interruption recovery controller
module dlr_lock_supervisor #(
   parameter int SHORT_CYC = dlr_pkg::DLR_SHORT_CYC,
   parameter int RECOVER_CYC = dlr_pkg::DLR_RECOVER_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire dlr_pkg::dlr_qam_t qam_pin,
   input wire dlr_pkg::dlr_mc_t mc_pin,
   input wire logic backup_avail_pin,
   input wire logic map_channel_pin,
   input wire logic params_same,
   input wire logic upstream_ok,
   input wire logic ranging_response_success,
   input wire logic ranging_response_timeout,
   input wire logic skew_done,
   output logic ds_valid,
   output logic lost_lock,
   output logic switch_backup,
   output logic seek_map_channel,
   output logic partial_mode,
   output logic status_report,
   output logic tx_hold,
   output logic us_suspend,
   output logic mac_reinit,
   output dlr_pkg::dlr_rng_req_t rng_req
);
   // state of the primary downstream
   typedef enum logic [2:0] {
      DLR_ST_LOCKED, DLR_ST_OUTAGE, DLR_ST_SKEW, DLR_ST_RANGE, DLR_ST_RESYNC
   } dlr_state_t;
   dlr_state_t state_reg, state_next;

   // two-flop synchronisers for pin inputs
   localparam int NIN = 16;
   logic [NIN-1:0] meta_reg, sync_reg;
   wire [NIN-1:0] raw_in = {qam_pin, mc_pin, backup_avail_pin, map_channel_pin};
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= raw_in;
         sync_reg <= meta_reg;
      end
   end
   dlr_pkg::dlr_qam_t qam;
   dlr_pkg::dlr_mc_t mc;
   wire backup_avail = sync_reg[1];
   wire map_channel = sync_reg[0];
   assign qam = sync_reg[15:12];
   assign mc = sync_reg[11:2];

   // configuration registers
   logic [31:0] ctrl_reg;
   logic [31:0] lostsync_reg, stmaint_reg, rngrsp_reg;
   logic [6:0] sticky_reg, sticky_next;
   wire prim_qam = ctrl_reg[dlr_pkg::DLR_CTRL_PRIM_QAM];
   wire backup_assigned = ctrl_reg[dlr_pkg::DLR_CTRL_BACKUP_ASSIGNED];
   wire skew_known = ctrl_reg[dlr_pkg::DLR_CTRL_SKEW_KNOWN];
   wire ts_suitable = ctrl_reg[dlr_pkg::DLR_CTRL_TS_SUITABLE];

   // validity of the primary channel
   wire qam_valid = qam.symbol_lock && qam.fec_lock && qam.packet_lock && qam.sync_msg_ok;
   // a pilot or preamble loss means clock timing is gone, so the channel is not valid
   wire mc_valid = mc.clock_ok && mc.link_ok && mc.pointer_ok && mc.base_fec_ok &&
                   !mc.pilot_err && !mc.preamble_loss;
   wire chan_valid = prim_qam ? qam_valid : mc_valid;
   // loss causes, qam ones and multicarrier ones
   wire qam_loss = !(qam.symbol_lock && qam.fec_lock && qam.packet_lock);
   wire mc_hard = mc.pilot_err || mc.preamble_loss;
   wire mc_soft = mc.link_fec_over || mc.pointer_crc_over || mc.base_fec_over;
   wire loss_now = prim_qam ? qam_loss : (mc_hard || mc_soft);
   logic loss_d_reg;
   wire loss_rise = loss_now && !loss_d_reg;
   // soft multicarrier causes keep the channel in use
   wire soft_only = !prim_qam && mc_soft && !mc_hard;
   wire hard_loss = loss_now && !soft_only;
   wire hard_rise = loss_rise && !soft_only;
   wire can_switch = backup_assigned && backup_avail;

   // timers
   logic [31:0] out_cnt_reg;
   logic [31:0] rec_cnt_reg;
   logic [4:0] t3_cnt_reg;
   logic ls_run, ls_exp, t4_exp, t3_exp;
   logic second_int_reg;
   wire in_outage = (state_reg == DLR_ST_OUTAGE);
   wire t3_give_up = t3_exp && (t3_cnt_reg == dlr_pkg::DLR_RNG_RETRY_MAX - 5'h01);
   wire reinit_now = (state_reg == DLR_ST_RESYNC) && (t4_exp || t3_give_up);

   // lost sync interval starts at a hard loss, stops on return
   dlr_timer #(.WIDTH(32)) u_lostsync (
      .sys_clk(sys_clk), .rst_n(rst_n),
      // on a multicarrier primary only a valid timestamp block ends the interval
      .start(hard_rise), .stop(chan_valid && (prim_qam || mc.timestamp_ok)),
      .load(lostsync_reg),
      .running(ls_run), .expired(ls_exp)
   );
   // station maintenance timer runs while resynchronising
   dlr_timer #(.WIDTH(32)) u_stmaint (
      .sys_clk(sys_clk), .rst_n(rst_n),
      .start(state_next == DLR_ST_RESYNC && state_reg != DLR_ST_RESYNC),
      .stop(state_reg != DLR_ST_RESYNC || ranging_response_success), .load(stmaint_reg),
      .running(), .expired(t4_exp)
   );
   // ranging response timer retriggers after each timeout
   dlr_timer #(.WIDTH(32)) u_rngrsp (
      .sys_clk(sys_clk), .rst_n(rst_n),
      .start((state_next == DLR_ST_RESYNC && state_reg != DLR_ST_RESYNC) || t3_exp),
      .stop(state_reg != DLR_ST_RESYNC || ranging_response_success), .load(rngrsp_reg),
      .running(), .expired(t3_exp)
   );

   // interruption qualification on return
   wire ret_ok = in_outage && chan_valid && params_same;
   wire short_ok = ret_ok && (out_cnt_reg <= 32'(SHORT_CYC));
   wire medium_ok = ret_ok && !short_ok && ls_run;

   // next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         DLR_ST_LOCKED: begin
            if (hard_rise) state_next = DLR_ST_OUTAGE;
         end
         DLR_ST_OUTAGE: begin
            if (short_ok || medium_ok) state_next = DLR_ST_RANGE;
            else if (chan_valid) state_next = DLR_ST_RANGE;
            // a ready backup is taken at once rather than waiting out the interval
            else if (can_switch) state_next = DLR_ST_SKEW;
            else if (ls_exp) state_next = DLR_ST_RESYNC;
         end
         DLR_ST_SKEW: begin
            if (skew_done || skew_known) state_next = DLR_ST_RANGE;
         end
         DLR_ST_RANGE: begin
            if (ranging_response_success) state_next = DLR_ST_LOCKED;
            else if (rec_cnt_reg == '0) state_next = DLR_ST_RESYNC;
            else if (hard_rise) state_next = DLR_ST_OUTAGE;
         end
         DLR_ST_RESYNC: begin
            if (reinit_now) state_next = DLR_ST_LOCKED;
            else if (chan_valid) state_next = DLR_ST_RANGE;
         end
         default: state_next = DLR_ST_LOCKED;
      endcase
   end

   // sticky flags: set wins over software clear
   wire [6:0] sticky_set = {soft_only && loss_rise, mc.base_fec_over, mc.pointer_crc_over,
                            mc.link_fec_over, mc.preamble_loss, mc.pilot_err,
                            prim_qam && qam_loss};
   wire clr_wr = reg_wr && (reg_addr == dlr_pkg::DLR_ADDR_STICKY);
   always_comb begin
      sticky_next = sticky_reg & ~(clr_wr ? reg_wdata[6:0] : 7'h00);
      sticky_next = sticky_next | sticky_set;
   end

   // state, counters, sticky
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= DLR_ST_LOCKED;
         // synced inputs reset to zero, which reads as lost; avoid a false edge
         loss_d_reg <= 1'b1;
         sticky_reg <= '0;
         out_cnt_reg <= '0;
         second_int_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         loss_d_reg <= loss_now;
         sticky_reg <= sticky_next;
         out_cnt_reg <= in_outage ? out_cnt_reg + 32'h00000001 : 32'h00000000;
         second_int_reg <= (state_reg == DLR_ST_RANGE) && hard_rise;
      end
   end

   // recovery window and retry count
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rec_cnt_reg <= '0;
         t3_cnt_reg <= '0;
      end else begin
         if (state_reg != DLR_ST_RANGE) rec_cnt_reg <= 32'(RECOVER_CYC);
         else if (rec_cnt_reg != '0) rec_cnt_reg <= rec_cnt_reg - 32'h00000001;
         if (state_reg != DLR_ST_RESYNC) t3_cnt_reg <= '0;
         else if (t3_exp) t3_cnt_reg <= t3_cnt_reg + 5'h01;
      end
   end

   // register writes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= dlr_pkg::DLR_CTRL_RESET;
         lostsync_reg <= dlr_pkg::DLR_LOSTSYNC_RESET;
         stmaint_reg <= dlr_pkg::DLR_STMAINT_RESET;
         rngrsp_reg <= dlr_pkg::DLR_RNGRSP_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            dlr_pkg::DLR_ADDR_CTRL: ctrl_reg <= reg_wdata;
            dlr_pkg::DLR_ADDR_LOSTSYNC: lostsync_reg <= reg_wdata;
            dlr_pkg::DLR_ADDR_STMAINT: stmaint_reg <= reg_wdata;
            dlr_pkg::DLR_ADDR_RNGRSP: rngrsp_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   // read mux, data one cycle after the strobe
   wire [31:0] stat_word = {25'h0000000, second_int_reg, 1'(chan_valid), 2'h0, state_reg};
   logic [31:0] rd_sel;
   always_comb begin
      case (reg_addr)
         dlr_pkg::DLR_ADDR_CTRL: rd_sel = ctrl_reg;
         dlr_pkg::DLR_ADDR_STAT: rd_sel = stat_word;
         dlr_pkg::DLR_ADDR_STICKY: rd_sel = {25'h0000000, sticky_reg};
         dlr_pkg::DLR_ADDR_LOSTSYNC: rd_sel = lostsync_reg;
         dlr_pkg::DLR_ADDR_STMAINT: rd_sel = stmaint_reg;
         dlr_pkg::DLR_ADDR_RNGRSP: rd_sel = rngrsp_reg;
         default: rd_sel = 32'h00000000;
      endcase
   end

   // registered outputs
   logic [31:0] rdata_reg;
   logic lost_reg, report_reg, switch_reg, reinit_reg, seek_reg;
   dlr_pkg::dlr_rng_req_t rng_reg;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= '0;
         lost_reg <= 1'b0;
         report_reg <= 1'b0;
         switch_reg <= 1'b0;
         reinit_reg <= 1'b0;
         seek_reg <= 1'b0;
         rng_reg <= '0;
      end else begin
         rdata_reg <= reg_rd ? rd_sel : 32'h00000000;
         lost_reg <= loss_rise;
         report_reg <= loss_rise && upstream_ok;
         switch_reg <= (state_reg == DLR_ST_OUTAGE) && (state_next == DLR_ST_SKEW);
         reinit_reg <= reinit_now;
         seek_reg <= hard_loss && map_channel;
         rng_reg.valid <= (state_next == DLR_ST_RANGE) && (state_reg != DLR_ST_RANGE);
         // unsuitable backup timestamp forces broadcast initial ranging
         rng_reg.kind <= (state_reg == DLR_ST_SKEW && !ts_suitable) ?
                         dlr_pkg::DLR_RNG_BCAST_INIT : dlr_pkg::DLR_RNG_STATION;
         rng_reg.spreader_on <= 1'b0;
         rng_reg.use_offset <= !(state_reg == DLR_ST_SKEW && !ts_suitable);
      end
   end

   assign reg_rdata = rdata_reg;
   assign ds_valid = chan_valid;
   assign lost_lock = lost_reg;
   assign status_report = report_reg;
   assign switch_backup = switch_reg;
   assign mac_reinit = reinit_reg;
   assign seek_map_channel = seek_reg;
   assign partial_mode = soft_only;
   // no transmit until skew compensated and ranging succeeded, or until a reinit is ordered
   assign tx_hold = (state_reg != DLR_ST_LOCKED);
   assign us_suspend = (state_reg == DLR_ST_RESYNC);
   assign rng_req = rng_reg;

   chk_skew_holds_tx: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_reg == DLR_ST_SKEW |-> tx_hold) else $error("tx during skew");
   chk_report_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
      loss_rise && upstream_ok |=> status_report) else $error("no report");
   chk_partial_soft: assert property (@(posedge sys_clk) disable iff (!rst_n)
      partial_mode |-> !prim_qam && !mc_hard) else $error("bad partial");
   chk_no_spreader: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rng_req.valid |-> !rng_req.spreader_on) else $error("spreader on");
   chk_lost_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(loss_now) |=> lost_lock) else $error("lost lock missed");
   chk_valid_qam: assert property (@(posedge sys_clk) disable iff (!rst_n)
      prim_qam && ds_valid |-> qam.sync_msg_ok && !qam_loss) else $error("qam valid");
   chk_reinit_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
      reinit_now |=> mac_reinit ##1 !mac_reinit) else $error("reinit");
   chk_sticky_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
      mc.pilot_err |=> sticky_reg[1]) else $error("sticky lost");
endmodule : dlr_lock_supervisor
`default_nettype wire

// [verilog/dlr_pkg.sv]
// What this block does
// - qam valid needs symbol, fec, packet, sync
// - multicarrier valid needs clock, link, pointers, fec
// - qam lost lock on any sync loss; code: symbol, fec or packet loss only, not sync message loss
// - multicarrier lost lock on five causes
// - seek maps elsewhere when map channel lost
// - lost primary switches to available backup
// - else resync until reinit order
// - fec-type causes keep channel, partial mode
// - status report when upstream available
// - interruption needs valid, same signal, parameters
// - short outage keeps code-division timing error
// - first burst timed within tight accuracy
// - short outage resumes within two seconds
// - medium outage may continue if recovered
// - else reacquire timing, range before transmit
// - range on maintenance slots, no spreader-on
// - ranging identifier, offset on station maintenance
// - hold transmit until backup skew compensated
// - lost sync interval forces switch or suspend
package dlr_pkg;
   // register offsets
   localparam logic [3:0] DLR_ADDR_CTRL = 4'h0;
   localparam logic [3:0] DLR_ADDR_STAT = 4'h1;
   localparam logic [3:0] DLR_ADDR_STICKY = 4'h2;
   localparam logic [3:0] DLR_ADDR_LOSTSYNC = 4'h3;
   localparam logic [3:0] DLR_ADDR_STMAINT = 4'h4;
   localparam logic [3:0] DLR_ADDR_RNGRSP = 4'h5;
   // control field positions
   localparam int DLR_CTRL_PRIM_QAM = 0;
   localparam int DLR_CTRL_BACKUP_ASSIGNED = 1;
   localparam int DLR_CTRL_SKEW_KNOWN = 2;
   localparam int DLR_CTRL_TS_SUITABLE = 3;
   localparam logic [31:0] DLR_CTRL_RESET = 32'h00000001;
   // timing
   localparam int DLR_CLK_HZ = 50000000;
   localparam int DLR_SHORT_US = 5000;
   localparam int DLR_SHORT_CYC = DLR_SHORT_US * (DLR_CLK_HZ / 1000000);
   localparam int DLR_RECOVER_MS = 2000;
   localparam int DLR_RECOVER_CYC = DLR_RECOVER_MS * (DLR_CLK_HZ / 1000);
   localparam logic [4:0] DLR_RNG_RETRY_MAX = 5'h11;
   localparam logic [31:0] DLR_LOSTSYNC_RESET = 32'h000F4240;
   localparam logic [31:0] DLR_STMAINT_RESET = 32'h01C9C380;
   localparam logic [31:0] DLR_RNGRSP_RESET = 32'h00989680;
   // ranging kinds
   typedef enum logic [1:0] {
      DLR_RNG_BCAST_INIT, DLR_RNG_UNI_INIT, DLR_RNG_STATION
   } dlr_rng_kind_t;
   // qam sync inputs
   typedef struct packed {
      logic symbol_lock;
      logic fec_lock;
      logic packet_lock;
      logic sync_msg_ok;
   } dlr_qam_t;
   // multicarrier health inputs
   typedef struct packed {
      logic clock_ok;
      logic link_ok;
      logic pointer_ok;
      logic base_fec_ok;
      logic pilot_err;
      logic preamble_loss;
      logic link_fec_over;
      logic pointer_crc_over;
      logic base_fec_over;
      logic timestamp_ok;
   } dlr_mc_t;
   // ranging request toward upstream mac
   typedef struct packed {
      logic valid;
      dlr_rng_kind_t kind;
      logic spreader_on;
      logic use_offset;
   } dlr_rng_req_t;
endpackage : dlr_pkg

// [verilog/dlr_timer.sv]
`timescale 1ns/10ps
`default_nettype none
// loadable down counter, flags expiry for one cycle
module dlr_timer #(
   parameter int WIDTH = 32
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic stop,
   input wire logic [WIDTH-1:0] load,
   output logic running,
   output logic expired
);
   logic [WIDTH-1:0] cnt_reg;
   logic run_reg;
   logic exp_reg;
   wire at_end = run_reg && (cnt_reg == '0);
   // start restarts, stop wins over expiry
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         exp_reg <= 1'b0;
      end else begin
         exp_reg <= at_end && !start && !stop;
         if (start) begin
            cnt_reg <= load;
            run_reg <= 1'b1;
         end else if (stop || at_end) begin
            run_reg <= 1'b0;
         end else if (run_reg) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
   assign running = run_reg;
   assign expired = exp_reg;
endmodule : dlr_timer
`default_nettype wire
